// *** core/atps_top.sv ***
// Trigger program select: routes two motor-drive triggers to stored
// conversion programs and routes program completion to two interrupts.
// Assumes triggers and done pulses come from logic on aclk, one cycle each.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module atps_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Motor drive trigger pulses
  input wire logic motor_drive_b_trigger_4,
  input wire logic motor_drive_b_trigger_5,
  // Program sequencer interface
  input wire logic [5:0] program_done,
  output logic start_10,
  output logic [2:0] program_number_10,
  output logic start_11,
  output logic [2:0] program_number_11,
  // Completion interrupts
  output logic program_done_irq_a,
  output logic program_done_irq_b
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic trigger_enable_10_q, trigger_enable_10_d; // Trigger 4 enable
  logic trigger_enable_11_q, trigger_enable_11_d; // Trigger 5 enable
  logic [2:0] prog_sel_10_q, prog_sel_10_d; // Trigger 4 program code
  logic [2:0] prog_sel_11_q, prog_sel_11_d; // Trigger 5 program code
  logic [1:0] route_q [atps_pkg::NUM_PROGS]; // Per-program route
  logic [1:0] route_d [atps_pkg::NUM_PROGS];
  logic [4:0] status_q, status_d; // Last start record

  // ************************************************************
  // Bus handshake state
  // ************************************************************
  logic bvalid_q, bvalid_d; // Write response pending
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d; // Read data pending
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go; // Address and data taken together
  logic rd_go; // Read address taken

  // ************************************************************
  // Sequencer-facing outputs
  // ************************************************************
  logic start_10_q, start_10_d;
  logic start_11_q, start_11_d;
  logic [2:0] num_10_q, num_10_d;
  logic [2:0] num_11_q, num_11_d;
  logic irq_a_q, irq_a_d;
  logic irq_b_q, irq_b_d;
  logic [5:0] hit_a; // Programs done and routed to A
  logic [5:0] hit_b; // Programs done and routed to B

  // Write waits for both channels so one edge takes both; simpler than
  // holding a half-written transfer, at the price of one idle cycle.
  assign wr_go = clk_en && awvalid && wvalid && !bvalid_q;
  assign awready = wr_go;
  assign wready = wr_go;
  // One read under way at a time
  assign rd_go = clk_en && arvalid && !rvalid_q;
  assign arready = rd_go;

  // ************************************************************
  // Register write decode
  // ************************************************************
  // Only byte lane 0 holds fields; upper lanes are read-only zero
  always_comb begin
    trigger_enable_10_d = trigger_enable_10_q;
    trigger_enable_11_d = trigger_enable_11_q;
    prog_sel_10_d = prog_sel_10_q;
    prog_sel_11_d = prog_sel_11_q;
    for (int i = 0; i < atps_pkg::NUM_PROGS; i++) begin
      route_d[i] = route_q[i];
    end
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    // Response leaves once the master takes it
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = atps_pkg::RESP_OKAY;
      if (awaddr[7:0] == atps_pkg::OFS_PSEL10) begin
        if (wstrb[0]) begin
          trigger_enable_10_d = wdata[atps_pkg::ENABLE_BIT];
          prog_sel_10_d = wdata[2:0];
        end
      end else if (awaddr[7:0] == atps_pkg::OFS_PSEL11) begin
        if (wstrb[0]) begin
          trigger_enable_11_d = wdata[atps_pkg::ENABLE_BIT];
          prog_sel_11_d = wdata[2:0];
        end
      end else if (awaddr[7:0] >= atps_pkg::OFS_ROUTE0 && awaddr[7:0] < atps_pkg::OFS_STATUS
                   && awaddr[1:0] == 2'h0) begin
        // Each route register serves its own program only
        if (wstrb[0]) begin
          route_d[3'((awaddr[7:0] - atps_pkg::OFS_ROUTE0) >> 2)] = wdata[1:0];
        end
      end else if (awaddr[7:0] == atps_pkg::OFS_STATUS) begin
        // Status is read-only; the write is absorbed
        bresp_d = atps_pkg::RESP_OKAY;
      end else begin
        // Unmapped address
        bresp_d = atps_pkg::RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // Register read decode
  // ************************************************************
  // Read data is captured when the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = atps_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (araddr[7:0] == atps_pkg::OFS_PSEL10) begin
        rdata_d[atps_pkg::ENABLE_BIT] = trigger_enable_10_q;
        rdata_d[2:0] = prog_sel_10_q;
      end else if (araddr[7:0] == atps_pkg::OFS_PSEL11) begin
        rdata_d[atps_pkg::ENABLE_BIT] = trigger_enable_11_q;
        rdata_d[2:0] = prog_sel_11_q;
      end else if (araddr[7:0] >= atps_pkg::OFS_ROUTE0 && araddr[7:0] < atps_pkg::OFS_STATUS
                   && araddr[1:0] == 2'h0) begin
        rdata_d[1:0] = route_q[3'((araddr[7:0] - atps_pkg::OFS_ROUTE0) >> 2)];
      end else if (araddr[7:0] == atps_pkg::OFS_STATUS) begin
        rdata_d[4:0] = status_q;
      end else begin
        // Unmapped address reads zero with an error
        rresp_d = atps_pkg::RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // Trigger to program start
  // ************************************************************
  // A reserved code starts nothing: there is no program to run, and
  // passing it on would let the sequencer index past its table.
  always_comb begin
    start_10_d = 1'b0;
    start_11_d = 1'b0;
    num_10_d = num_10_q;
    num_11_d = num_11_q;
    status_d = status_q;
    // Disabled triggers are simply dropped
    if (motor_drive_b_trigger_4 && trigger_enable_10_q
        && prog_sel_10_q <= atps_pkg::PROG_MAX) begin
      start_10_d = 1'b1;
      num_10_d = prog_sel_10_q;
      status_d = {1'b1, 1'b0, prog_sel_10_q};
    end
    if (motor_drive_b_trigger_5 && trigger_enable_11_q
        && prog_sel_11_q <= atps_pkg::PROG_MAX) begin
      start_11_d = 1'b1;
      num_11_d = prog_sel_11_q;
      // Trigger 5 is recorded last when both fire together
      status_d = {1'b1, 1'b1, prog_sel_11_q};
    end
  end

  // ************************************************************
  // Completion routing
  // ************************************************************
  // One route field per program; codes 00 and 11 raise nothing
  for (genvar g = 0; g < atps_pkg::NUM_PROGS; g++) begin : g_route
    assign hit_a[g] = program_done[g] && (route_q[g] == atps_pkg::ROUTE_TO_A);
    assign hit_b[g] = program_done[g] && (route_q[g] == atps_pkg::ROUTE_TO_B);
  end

  // Interrupt pulse lasts one cycle per done pulse
  always_comb begin
    irq_a_d = |hit_a;
    irq_b_d = |hit_b;
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Register fields and write response; synchronous reset, and
  // clock enable low freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_enable_10_q <= atps_pkg::SEL_RESET[atps_pkg::ENABLE_BIT];
      trigger_enable_11_q <= atps_pkg::SEL_RESET[atps_pkg::ENABLE_BIT];
      prog_sel_10_q <= atps_pkg::SEL_RESET[2:0];
      prog_sel_11_q <= atps_pkg::SEL_RESET[2:0];
      for (int i = 0; i < atps_pkg::NUM_PROGS; i++) begin
        route_q[i] <= atps_pkg::ROUTE_RESET;
      end
      bvalid_q <= 1'b0;
      bresp_q <= atps_pkg::RESP_OKAY;
    end else if (clk_en) begin
      trigger_enable_10_q <= trigger_enable_10_d;
      trigger_enable_11_q <= trigger_enable_11_d;
      prog_sel_10_q <= prog_sel_10_d;
      prog_sel_11_q <= prog_sel_11_d;
      for (int i = 0; i < atps_pkg::NUM_PROGS; i++) begin
        route_q[i] <= route_d[i];
      end
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // Read response; data is held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= atps_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Program starts and the record of the last start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_10_q <= 1'b0;
      start_11_q <= 1'b0;
      num_10_q <= 3'h0;
      num_11_q <= 3'h0;
      status_q <= atps_pkg::STATUS_RESET;
    end else if (clk_en) begin
      start_10_q <= start_10_d;
      start_11_q <= start_11_d;
      num_10_q <= num_10_d;
      num_11_q <= num_11_d;
      status_q <= status_d;
    end
  end

  // Completion interrupt pulses; a done pulse seen while frozen is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else if (clk_en) begin
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign start_10 = start_10_q;
  assign start_11 = start_11_q;
  assign program_number_10 = num_10_q;
  assign program_number_11 = num_11_q;
  assign program_done_irq_a = irq_a_q;
  assign program_done_irq_b = irq_b_q;

endmodule

// *** core/atps_pkg.sv ***
// Constants shared by the trigger program select block.
// Assumes a 32-bit AXI4-Lite register bus and six conversion programs.
package atps_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_PSEL10 = 8'h00; // Trigger 4 selector
  localparam logic [7:0] OFS_PSEL11 = 8'h04; // Trigger 5 selector
  localparam logic [7:0] OFS_ROUTE0 = 8'h08; // Program 0 route, next five follow
  localparam logic [7:0] OFS_STATUS = 8'h20; // Last start seen
  localparam logic [7:0] ROUTE_STEP = 8'h04; // Spacing of route registers

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int ENABLE_BIT = 7; // Trigger enable position
  localparam int PROG_W = 3; // Program number width
  localparam int ROUTE_W = 2; // Interrupt route width
  localparam int NUM_PROGS = 6; // Stored conversion programs
  localparam logic [2:0] PROG_MAX = 3'h5; // Highest legal program code
  localparam int STAT_SRC_BIT = 3; // Status: source of last start
  localparam int STAT_SEEN_BIT = 4; // Status: any start since reset

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] ROUTE_TO_A = 2'h1; // Raise done interrupt A
  localparam logic [1:0] ROUTE_TO_B = 2'h2; // Raise done interrupt B
  localparam logic [7:0] SEL_RESET = 8'h00; // Selector after reset
  localparam logic [1:0] ROUTE_RESET = 2'h0; // No interrupt after reset
  localparam logic [4:0] STATUS_RESET = 5'h00; // Status after reset
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error
endpackage

// *** dv/atps_assertions.sv ***
// Checker for the trigger program select block.
// Assumes it is bound to atps_top and sees only its ports.
module atps_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic motor_drive_b_trigger_4,
  input wire logic motor_drive_b_trigger_5,
  input wire logic [5:0] program_done,
  input wire logic start_10,
  input wire logic [2:0] program_number_10,
  input wire logic start_11,
  input wire logic [2:0] program_number_11,
  input wire logic program_done_irq_a,
  input wire logic program_done_irq_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties, all on aclk
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels offered and slave free
  sequence s_wr_taken;
    awvalid && wvalid && clk_en && !bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> bvalid) else $error("write not answered");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid) else $error("rvalid dropped early");
  a_start_a_cause: assert property (start_10 |-> $past(motor_drive_b_trigger_4 && clk_en))
    else $error("start_10 without trigger");
  a_start_b_cause: assert property (start_11 |-> $past(motor_drive_b_trigger_5 && clk_en))
    else $error("start_11 without trigger");
  a_number_legal: assert property (start_10 || start_11 |-> program_number_10 <= 3'h5
    && program_number_11 <= 3'h5) else $error("reserved program started");
  a_irq_cause: assert property (program_done_irq_a || program_done_irq_b |-> $past(|program_done))
    else $error("irq without program done");
  a_reset_clear: assert property ($past(!aresetn) |-> !start_10 && !start_11
    && !program_done_irq_a && !program_done_irq_b && program_number_10 == 3'h0) else $error("reset not clear");
endmodule

bind atps_top atps_assertions u_atps_assertions (.aclk, .aresetn, .clk_en, .awvalid, .wvalid, .bvalid,
  .bready, .rvalid, .rready, .motor_drive_b_trigger_4, .motor_drive_b_trigger_5, .program_done, .start_10,
  .program_number_10, .start_11, .program_number_11, .program_done_irq_a, .program_done_irq_b);

// *** dv/atps_partner.sv ***
// Far side model: motor drive trigger source and program sequencer.
// Assumes the bench pulses fire_4 or fire_5 for one aclk cycle.
module atps_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire_4,
  input wire logic fire_5,
  input wire logic slow,
  input wire logic start_10,
  input wire logic start_11,
  input wire logic [2:0] program_number_10,
  input wire logic [2:0] program_number_11,
  output logic motor_drive_b_trigger_4,
  output logic motor_drive_b_trigger_5,
  output logic [5:0] program_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q, wait_d; // Cycles left
  logic [2:0] prog_q, prog_d; // Program running
  logic busy_q, busy_d; // Sequencer busy
  logic [5:0] done_d; // Finish pulses
  // One program at a time; a new start replaces it, trigger 5 wins
  always_comb begin
    wait_d = wait_q;
    prog_d = prog_q;
    busy_d = busy_q;
    done_d = 6'h00;
    if (busy_q && wait_q == 4'h0) begin
      busy_d = 1'b0;
      done_d[prog_q] = 1'b1;
    end else if (busy_q) begin
      wait_d = wait_q - 4'h1;
    end
    if (start_10 || start_11) begin
      busy_d = 1'b1;
      prog_d = start_11 ? program_number_11 : program_number_10;
      wait_d = slow ? 4'h9 : 4'h0;
    end
  end
  // Triggers are one-cycle copies of the bench's requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wait_q, prog_q, busy_q, program_done, motor_drive_b_trigger_4, motor_drive_b_trigger_5} <= '0;
    end else begin
      {wait_q, prog_q, busy_q, program_done} <= {wait_d, prog_d, busy_d, done_d};
      {motor_drive_b_trigger_4, motor_drive_b_trigger_5} <= {fire_4, fire_5};
    end
  end
endmodule

// *** dv/test_adc_trigger_program_select.sv ***
// Bench for the trigger program select block.
// Assumes the design, its checker bind and the partner model.
module test_adc_trigger_program_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = atps_pkg::RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic fire_4 = 1'b0, fire_5 = 1'b0, slow = 1'b0, clk_en = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, start_10, start_11, irq_a, irq_b, trg_4, trg_5;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] done;
  logic [2:0] num_10, num_11, n10, n11;
  logic s10, s11, sa, sb;
  int bad_count = 0;
  int check_count = 0;
  always #20 aclk = ~aclk;
  atps_top u_atps_top (.aclk, .aresetn, .clk_en, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .motor_drive_b_trigger_4(trg_4), .motor_drive_b_trigger_5(trg_5),
    .program_done(done), .start_10, .program_number_10(num_10), .start_11, .program_number_11(num_11),
    .program_done_irq_a(irq_a), .program_done_irq_b(irq_b));
  atps_partner u_atps_partner (.aclk, .aresetn, .fire_4, .fire_5, .slow, .start_10, .start_11,
    .program_number_10(num_10), .program_number_11(num_11), .motor_drive_b_trigger_4(trg_4),
    .motor_drive_b_trigger_5(trg_5), .program_done(done));
  // ****
  // Shared tasks
  // ****
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait step; a hang ends the run
  task automatic tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 50) begin
      bad_count++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do tick(n); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do tick(n); while (bvalid !== 1'b1);
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
    // Ready comes a cycle late, so the response must stand for it
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    cmp("rdata", ev, rdata);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Pulse triggers, then watch starts and interrupts long enough for a slow program
  task automatic fire(input logic f4, input logic f5);
    {s10, s11, sa, sb} = 4'h0;
    // Reserved code as marker, so a missing start is not hidden by an old number
    {n10, n11} = 6'h3F;
    @(posedge aclk);
    fire_4 <= f4;
    fire_5 <= f5;
    @(posedge aclk);
    fire_4 <= 1'b0;
    fire_5 <= 1'b0;
    repeat (24) begin
      @(negedge aclk);
      if (start_10 === 1'b1) n10 = num_10;
      if (start_11 === 1'b1) n11 = num_11;
      {s10, s11, sa, sb} = {s10, s11, sa, sb} | {start_10 === 1'b1, start_11 === 1'b1, irq_a === 1'b1, irq_b === 1'b1};
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    for (int i = 0; i <= 8; i++) rd(8'(i * 4), 32'h0, OK);
    wr(atps_pkg::OFS_PSEL10, 32'hFFFF_FFFF, OK);
    rd(atps_pkg::OFS_PSEL10, 32'h0000_0087, OK);
    wr(atps_pkg::OFS_ROUTE0, 32'hFFFF_FFFF, OK);
    rd(atps_pkg::OFS_ROUTE0, 32'h0000_0003, OK);
    wstrb <= 4'h0;
    wr(atps_pkg::OFS_ROUTE0, 32'h0, OK);
    wstrb <= 4'hF;
    rd(atps_pkg::OFS_ROUTE0, 32'h0000_0003, OK);
    wr(8'h40, 32'h1, atps_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, atps_pkg::RESP_SLVERR);
    wr(atps_pkg::OFS_ROUTE0, 32'h0, OK);
    $display("test registers done");
  endtask
  task automatic t_enable();
    wr(atps_pkg::OFS_PSEL10, 32'h0000_0002, OK);
    wr(atps_pkg::OFS_PSEL11, 32'h0000_0004, OK);
    fire(1'b1, 1'b1);
    cmp("start_10 disabled", 32'h0, {31'h0, s10});
    cmp("start_11 disabled", 32'h0, {31'h0, s11});
    wr(atps_pkg::OFS_PSEL10, 32'h0000_0082, OK);
    wr(atps_pkg::OFS_PSEL11, 32'h0000_0084, OK);
    fire(1'b1, 1'b1);
    cmp("start_10 enabled", 32'h1, {31'h0, s10});
    cmp("program_number_10", 32'h2, {29'h0, n10});
    cmp("start_11 enabled", 32'h1, {31'h0, s11});
    cmp("program_number_11", 32'h4, {29'h0, n11});
    rd(atps_pkg::OFS_STATUS, 32'h0000_001C, OK);
    wr(atps_pkg::OFS_STATUS, 32'hFFFF_FFFF, OK);
    rd(atps_pkg::OFS_STATUS, 32'h0000_001C, OK);
    $display("test enables done");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      wr(atps_pkg::OFS_PSEL11, 32'h80 | 32'(c), OK);
      fire(1'b0, 1'b1);
      cmp("start_11 code", (c <= 5) ? 32'h1 : 32'h0, {31'h0, s11});
      if (c <= 5) cmp("program code", 32'(c), {29'h0, n11});
    end
    $display("test codes done");
  endtask
  // Each route register set alone; a swapped mapping leaves the pulse missing
  task automatic t_routes();
    for (int p = 0; p < 6; p++) begin
      wr(atps_pkg::OFS_PSEL10, 32'h80 | 32'(p), OK);
      for (int r = 0; r < 4; r++) begin
        wr(atps_pkg::OFS_ROUTE0 + 8'(p * 4), 32'(r), OK);
        slow <= r[0];
        fire(1'b1, 1'b0);
        cmp("irq_a", (r == 1) ? 32'h1 : 32'h0, {31'h0, sa});
        cmp("irq_b", (r == 2) ? 32'h1 : 32'h0, {31'h0, sb});
      end
      wr(atps_pkg::OFS_ROUTE0 + 8'(p * 4), 32'h0, OK);
    end
    $display("test routes done");
  endtask
  // Clock enable low drops a trigger; a reset in mid-run clears written fields
  task automatic t_freeze_reset();
    @(posedge aclk);
    clk_en <= 1'b0;
    fire(1'b1, 1'b0);
    cmp("start_10 frozen", 32'h0, {31'h0, s10});
    @(posedge aclk);
    clk_en <= 1'b1;
    rd(atps_pkg::OFS_STATUS, 32'h0000_0015, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(atps_pkg::OFS_PSEL10, 32'h0, OK);
    rd(atps_pkg::OFS_STATUS, 32'h0, OK);
    $display("test freeze and reset done");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_enable();
    t_codes();
    t_routes();
    t_freeze_reset();
    results();
  end
endmodule
